/* File: rtl/mis_pkg.sv */
// Package: register map, field positions, carriers for the monitor status block
package mis_pkg;
	localparam int ADDR_W = 8;
	// Register indices; the bus byte address is the index times four
	localparam logic [7:0] PRI_IDX = 8'h41;
	localparam logic [7:0] SEC_IDX = 8'h42;
	localparam logic [7:0] STS3_IDX = 8'h7D;
	localparam logic [7:0] CTRL_IDX = 8'h40;
	localparam logic [7:0] IRQ_STAT_IDX = 8'h50;
	localparam logic [7:0] IRQ_MASK_IDX = 8'h51;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_IRQ = 8'h00;
	localparam logic [7:0] DIODE_FAULT_READING = 8'h80;
	localparam int PRI_SUMMARY_BIT = 7;
	localparam int SEC_RES_BIT = 1;
	localparam int PRI_ZONE1_BIT = 4;
	localparam int PRI_ZONE3_BIT = 6;
	localparam int SEC_D1_FAULT_BIT = 6;
	localparam int SEC_D2_FAULT_BIT = 7;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_D1_EN_BIT = 1;
	localparam int CTRL_D2_EN_BIT = 2;
	localparam int IRQ_PRI_BIT = 0;
	localparam int IRQ_SEC_BIT = 1;
	localparam int N_VOLT = 5;
	localparam int N_ZONE = 3;
	localparam int N_FAN = 4;

	// One 8-bit reading with its low and high limits
	typedef struct packed {
		logic [7:0] reading;
		logic [7:0] low;
		logic [7:0] high;
	} mis_limit_t;

	// One 16-bit tachometer count with its minimum
	typedef struct packed {
		logic [15:0] reading;
		logic [15:0] minimum;
	} mis_tach_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [31:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} mis_wb_req_t;
endpackage : mis_pkg

/* File: rtl/mis_status.sv */
// Latching event status registers of a hardware monitor behind a classic Wishbone slave
//
// Function
// R1 - Supply bits 0..3 latch when reading is at/below low or above high limit.
// R2 - Zone bits 4..6 latch when temperature is at/below low or above high limit.
// R3 - Set bits hold until read; read clears them only if condition has gone.
// R4 - A bit never clears merely because its condition returned within limits.
// R5 - Primary bit 7 is high whenever any secondary or third status bit is set.
// R6 - Primary bit 7 clears automatically once secondary and third are all clear.
// R7 - Both status registers are read only; writes leave them unchanged.
// R8 - Secondary bit 0 latches 12V limit violation; bit 1 is reserved.
// R9 - Secondary bits 2..5 latch a stall when tach reading exceeds its minimum.
// R10 - A read clears a stall bit only if the fan reading is back within minimum.
// R11 - Secondary bits 6 and 7 latch short/open faults on diode 1 and 2.
// R12 - A read never clears a diode fault bit while the fault persists.
// R13 - When started, a diode fault forces reading 80h, setting its zone bit where 80h is outside the zone limits.
// R14 - Disabling a diode channel clears its fault bit and its zone bit.
// R15 - With monitoring stopped, no status bit is set except the summary bit 7.
// R16 - Active conditions survive a read; the reserved bit always reads zero.
module mis_status
(
	input wire logic clk_i, // System clock, 200 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire mis_pkg::mis_wb_req_t wb_req_i, // Wishbone request group
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire mis_pkg::mis_limit_t [mis_pkg::N_VOLT-1:0] volt_i, // 2.5V,core,3.3V,5V,12V
	input wire mis_pkg::mis_limit_t [mis_pkg::N_ZONE-1:0] zone_i, // Zones 1..3
	input wire mis_pkg::mis_tach_t [mis_pkg::N_FAN-1:0] tach_i, // Fans 1..4
	input wire logic [1:0] diode_fault_i, // Short/open on diode 1,2
	input wire logic [2:0] sts3_i, // Any-bit-set levels of the third register
	output logic irq_o // Level interrupt, unmasked event pending
);
	import mis_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Limit comparison, shared by supplies and zones
	function automatic logic out_of_limit(input mis_limit_t v);
		out_of_limit = (v.reading <= v.low) || (v.reading > v.high);
	endfunction : out_of_limit

	function automatic logic [7:0] word_index(input logic [31:0] adr);
		word_index = adr[9:2];
	endfunction : word_index

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] pri_reg, pri_next;
	logic [7:0] sec_reg, sec_next;
	logic [7:0] istat_reg, istat_next;
	logic [7:0] imask_reg, imask_next;
	logic [31:0] dat_reg, dat_next;
	logic ack_reg, ack_next;
	logic irq_reg, irq_next;

	logic access;
	logic rd_pri, rd_sec, rd_istat;
	logic [7:0] idx;
	logic start, d1_en, d2_en;

	// Single-cycle answer: ack follows one edge after stb, then drops for the release cycle
	assign access = wb_req_i.cyc && wb_req_i.stb && !ack_reg;
	assign idx = word_index(wb_req_i.adr);
	assign rd_pri = access && !wb_req_i.we && (idx == PRI_IDX);
	assign rd_sec = access && !wb_req_i.we && (idx == SEC_IDX);
	assign rd_istat = access && !wb_req_i.we && (idx == IRQ_STAT_IDX);
	assign start = ctrl_reg[CTRL_START_BIT];
	assign d1_en = ctrl_reg[CTRL_D1_EN_BIT];
	assign d2_en = ctrl_reg[CTRL_D2_EN_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Condition evaluation
	logic [N_VOLT-1:0] volt_bad;
	logic [N_ZONE-1:0] zone_bad;
	logic [N_FAN-1:0] fan_stall;
	logic [1:0] diode_bad;
	logic [7:0] pri_cond, sec_cond;

	genvar g;
	generate
		for (g = 0; g < N_VOLT; g++) begin : g_volt
			assign volt_bad[g] = out_of_limit(volt_i[g]); // [R1] [R8]
		end
		for (g = 0; g < N_FAN; g++) begin : g_fan
			assign fan_stall[g] = tach_i[g].reading > tach_i[g].minimum; // [R9]
		end
	endgenerate

	// A faulted diode reads as 80h, so its zone is judged on that value
	always_comb begin
		mis_limit_t z;
		z = '0;
		diode_bad[0] = diode_fault_i[0] && d1_en;
		diode_bad[1] = diode_fault_i[1] && d2_en;
		for (int i = 0; i < N_ZONE; i++) begin
			z = zone_i[i];
			if ((i == 0 && diode_bad[0]) || (i == 2 && diode_bad[1])) begin
				z.reading = DIODE_FAULT_READING; // [R13]
			end
			zone_bad[i] = out_of_limit(z); // [R2]
		end
		// Disabled remote channels raise no zone event [R14]
		if (!d1_en) begin
			zone_bad[0] = 1'b0;
		end
		if (!d2_en) begin
			zone_bad[2] = 1'b0;
		end
	end

	assign pri_cond = {1'b0, zone_bad, volt_bad[3:0]};
	assign sec_cond = {diode_bad[1], diode_bad[0], fan_stall, 1'b0, volt_bad[4]};

	////////////////////////////////////////////////////////////////////////////////
	// Status latching
	always_comb begin
		logic [7:0] pset, sset;
		pset = start ? pri_cond : 8'h00; // [R15]
		sset = start ? sec_cond : 8'h00; // [R15]
		pri_next = pri_reg;
		sec_next = sec_reg;
		// Read clears only what is no longer active; set wins in the same cycle [R3] [R16]
		if (rd_pri) begin
			pri_next = pri_reg & pri_cond;
		end
		if (rd_sec) begin
			sec_next = sec_reg & sec_cond; // [R10] [R12]
		end
		// Otherwise the bits hold; nothing here follows the condition falling [R4]
		pri_next = pri_next | pset; // [R1] [R2]
		sec_next = sec_next | sset; // [R8] [R9] [R11]
		if (!d1_en) begin
			pri_next[PRI_ZONE1_BIT] = 1'b0; // [R14]
			sec_next[SEC_D1_FAULT_BIT] = 1'b0; // [R14]
		end
		if (!d2_en) begin
			pri_next[PRI_ZONE3_BIT] = 1'b0; // [R14]
			sec_next[SEC_D2_FAULT_BIT] = 1'b0; // [R14]
		end
		sec_next[SEC_RES_BIT] = 1'b0; // [R16]
		// Summary is live, never latched [R5] [R6]
		pri_next[PRI_SUMMARY_BIT] = (|sec_next) || (|sts3_i);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control, interrupt, bus answer
	always_comb begin
		logic [7:0] ev;
		ev = 8'h00;
		ctrl_next = ctrl_reg;
		imask_next = imask_reg;
		ev[IRQ_PRI_BIT] = |(pri_next & ~pri_reg);
		ev[IRQ_SEC_BIT] = |(sec_next & ~sec_reg);
		istat_next = (rd_istat ? 8'h00 : istat_reg) | ev;
		if (access && wb_req_i.we && wb_req_i.sel[0]) begin
			// Status registers take no write [R7]
			unique case (idx)
				CTRL_IDX: ctrl_next = wb_req_i.dat[7:0];
				IRQ_MASK_IDX: imask_next = wb_req_i.dat[7:0];
				default: ;
			endcase
		end
		dat_next = 32'h0000_0000;
		if (access && !wb_req_i.we) begin
			unique case (idx)
				CTRL_IDX: dat_next[7:0] = ctrl_reg;
				PRI_IDX: dat_next[7:0] = pri_reg;
				SEC_IDX: dat_next[7:0] = sec_reg;
				IRQ_STAT_IDX: dat_next[7:0] = istat_reg;
				IRQ_MASK_IDX: dat_next[7:0] = imask_reg;
				default: dat_next = 32'h0000_0000;
			endcase
		end
		ack_next = access;
		irq_next = |(istat_next & imask_next);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= RST_CTRL;
			pri_reg <= RST_STATUS;
			sec_reg <= RST_STATUS;
			istat_reg <= RST_IRQ;
			imask_reg <= RST_MASK;
			dat_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			pri_reg <= pri_next;
			sec_reg <= sec_next;
			istat_reg <= istat_next;
			imask_reg <= imask_next;
			dat_reg <= dat_next;
			ack_reg <= ack_next;
			irq_reg <= irq_next;
		end
	end

	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;
	assign irq_o = irq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	logic wr_sts;
	assign wr_sts = access && wb_req_i.we && (idx == PRI_IDX || idx == SEC_IDX);

	sequence s_read_pri;
		rd_pri;
	endsequence

	AST_VOLT_SET: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		(start && volt_bad[0] && d1_en) |=> pri_reg[0])
		else $error("supply bit 0 not latched");
	AST_ZONE_SET: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		(start && zone_bad[1]) |=> pri_reg[5])
		else $error("zone 2 bit not latched");
	AST_READ_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
		(s_read_pri ##0 (pri_reg[2] && volt_bad[2] && d1_en && d2_en)) |=> pri_reg[2])
		else $error("active bit cleared by read");
	AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		(pri_reg[3] && !rd_pri) |=> pri_reg[3])
		else $error("bit dropped without read");
	AST_SUMMARY: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
		((|sec_reg) && !rst_i) |-> pri_reg[PRI_SUMMARY_BIT] || $past(rst_i))
		else $error("summary missing");
	AST_SUMMARY_CLR: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		(sec_reg == 8'h00 && $stable(sts3_i) && sts3_i == 3'h0 && !$rose(start))
		|-> !pri_reg[PRI_SUMMARY_BIT])
		else $error("summary stuck");
	AST_RO: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		(wr_sts && !start && d1_en && d2_en) |=> (pri_reg[6:0] == $past(pri_reg[6:0])))
		else $error("status changed by write");
	AST_STALL: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
		(start && fan_stall[3]) |=> sec_reg[5])
		else $error("stall not latched");
	AST_FAULT_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
		(rd_sec && sec_reg[7] && diode_bad[1]) |=> sec_reg[7])
		else $error("fault cleared while present");
	AST_DISABLE: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
		!d1_en |=> !pri_reg[4] && !sec_reg[6])
		else $error("disabled diode bits set");
	AST_STOPPED: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
		(!start && pri_reg[6:0] == 7'h00 && !rd_pri) |=> pri_reg[6:0] == 7'h00)
		else $error("bit set while stopped");
	AST_RES: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
		!sec_reg[SEC_RES_BIT])
		else $error("reserved bit set");

	////////////////////////////////////////////////////////////////////////////////
	// Bus answer, interrupt path and further rule checks
	logic wr_ctrl;
	logic pri_moves, sec_moves;
	assign wr_ctrl = access && wb_req_i.we && wb_req_i.sel[0] && (idx == CTRL_IDX);
	assign pri_moves = |(pri_next & ~pri_reg);
	assign sec_moves = |(sec_next & ~sec_reg);

	// A taken request sees one acknowledge cycle and then a gap
	sequence s_take;
		access;
	endsequence

	sequence s_answer;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	// Forced 80h also counts at or below the zone floor; these sequences take only the case above the ceiling
	sequence s_diode1_forced;
		start && diode_bad[0] && (zone_i[0].high < DIODE_FAULT_READING);
	endsequence

	sequence s_diode2_forced;
		start && diode_bad[1] && (zone_i[2].high < DIODE_FAULT_READING);
	endsequence

	AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		s_take |=> s_answer)
		else $error("acknowledge not a single cycle");

	AST_ACK_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> $past(access))
		else $error("acknowledge without request");

	AST_DAT_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
		else $error("read data outside acknowledge");

	AST_DAT_LANE: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> (wb_dat_o[31:8] == 24'h00_0000))
		else $error("upper read lanes not zero");

	AST_CTRL_WR: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl |=> (ctrl_reg == $past(wb_req_i.dat[7:0])))
		else $error("control write lost");

	// Not gated by reset, so it watches the release itself
	AST_RESET_CLEAN: assert property (@(posedge clk_i)
		$past(rst_i) |-> (!wb_ack_o && !irq_o && pri_reg == RST_STATUS
		&& sec_reg == RST_STATUS && ctrl_reg == RST_CTRL))
		else $error("state not cleared by reset");

	// Rule checks on bits the first group leaves open
	AST_VOLT3_SET: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		(start && volt_bad[3]) |=> pri_reg[3])
		else $error("supply bit 3 not latched");

	AST_ZONE1_SET: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		(start && zone_bad[0]) |=> pri_reg[PRI_ZONE1_BIT])
		else $error("zone 1 bit not latched");

	AST_READ_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
		(rd_pri && !volt_bad[1]) |=> !pri_reg[1])
		else $error("inactive bit survived read");

	AST_HOLD_SEC: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		(sec_reg[2] && !rd_sec) |=> sec_reg[2])
		else $error("stall bit dropped without read");

	AST_SUMMARY_STS3: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
		(|sts3_i) |=> pri_reg[PRI_SUMMARY_BIT])
		else $error("summary missing for third register");

	AST_SUMMARY_EXACT: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		!$past(rst_i) |-> (pri_reg[PRI_SUMMARY_BIT] == ((|sec_reg) || (|$past(sts3_i)))))
		else $error("summary does not follow sources");

	AST_RO_PRI_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		(wr_sts && d1_en && d2_en) |=> (($past(pri_reg[6:0]) & ~pri_reg[6:0]) == 7'h00))
		else $error("primary bit cleared by write");

	AST_RO_SEC_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		(wr_sts && d1_en && d2_en) |=> (($past(sec_reg) & ~sec_reg) == 8'h00))
		else $error("secondary bit cleared by write");

	AST_12V_SET: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
		(start && volt_bad[4]) |=> sec_reg[0])
		else $error("12V bit not latched");

	AST_STALL1_SET: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
		(start && fan_stall[0]) |=> sec_reg[2])
		else $error("fan 1 stall not latched");

	AST_STALL_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
		(rd_sec && !fan_stall[1]) |=> !sec_reg[3])
		else $error("stall bit survived read");

	AST_FAULT1_SET: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		(start && diode_bad[0]) |=> sec_reg[SEC_D1_FAULT_BIT])
		else $error("diode 1 fault not latched");

	AST_FAULT1_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
		(rd_sec && sec_reg[SEC_D1_FAULT_BIT] && diode_bad[0]) |=> sec_reg[SEC_D1_FAULT_BIT])
		else $error("diode 1 fault cleared while present");

	AST_FORCED1: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
		s_diode1_forced |=> (pri_reg[PRI_ZONE1_BIT] && sec_reg[SEC_D1_FAULT_BIT]))
		else $error("diode 1 fault did not raise zone 1");

	AST_FORCED2: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
		s_diode2_forced |=> (pri_reg[PRI_ZONE3_BIT] && sec_reg[SEC_D2_FAULT_BIT]))
		else $error("diode 2 fault did not raise zone 3");

	AST_DISABLE2: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
		!d2_en |=> (!pri_reg[PRI_ZONE3_BIT] && !sec_reg[SEC_D2_FAULT_BIT]))
		else $error("disabled diode 2 bits set");

	AST_STOPPED_SEC: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
		(!start && sec_reg == 8'h00) |=> (sec_reg == 8'h00))
		else $error("secondary bit set while stopped");

	AST_READ_KEEP_SEC: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
		(rd_sec && sec_reg[0] && volt_bad[4]) |=> sec_reg[0])
		else $error("active 12V bit cleared by read");

	// Interrupt path: level follows the registered status and mask
	AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == (|(istat_reg & imask_reg)))
		else $error("interrupt level wrong");
	AST_EVENT_PRI: assert property (@(posedge clk_i) disable iff (rst_i)
		pri_moves |=> istat_reg[IRQ_PRI_BIT])
		else $error("primary event not recorded");
	AST_EVENT_SEC: assert property (@(posedge clk_i) disable iff (rst_i)
		sec_moves |=> istat_reg[IRQ_SEC_BIT])
		else $error("secondary event not recorded");
	AST_ISTAT_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_istat && !pri_moves && !sec_moves) |=> (istat_reg == 8'h00))
		else $error("interrupt status not cleared by read");
endmodule : mis_status

/* File: bench/mis_status_tb.sv */
// Self-checking bench for the latching monitor status registers
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end
module mis_status_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mis_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	mis_wb_req_t req = '0;
	logic [31:0] dat;
	logic [31:0] e;
	logic ack;
	logic irq;
	mis_limit_t [N_VOLT-1:0] volt;
	mis_limit_t [N_ZONE-1:0] zone;
	mis_tach_t [N_FAN-1:0] tach;
	logic [1:0] dfl = 2'b00;
	logic [2:0] sts3 = 3'b000;
	int mismatches = 0;
	int checked = 0;
	logic [7:0] expq[$];

	always #2.5 clk_i = ~clk_i;

	mis_status mis_status_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat),
		.wb_ack_o(ack), .volt_i(volt), .zone_i(zone), .tach_i(tach), .diode_fault_i(dfl),
		.sts3_i(sts3), .irq_o(irq));

	////////////////////////////////////////////////////////////////////////////////
	// Read results are matched against the oldest noted expectation
	always @(posedge clk_i) begin
		if (ack === 1'b1 && req.we === 1'b0) begin
			e = (expq.size() > 0) ? {24'h0, expq.pop_front()} : 32'hDEADBEEF;
			`CHK(dat, e)
		end
	end

	task automatic report_and_stop();
		$display("Counts: %0d checked, %0d mismatches", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	// Held until ack is sampled, then one idle cycle before the next transfer
	task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
		int n;
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {22'h0, idx, 2'b00}, sel: 4'h1, dat: {24'h0, d}};
		for (n = 0; n < 20 && ack !== 1'b1; n++)
			@(posedge clk_i);
		if (ack !== 1'b1) begin
			mismatches++;
			report_and_stop();
		end
		req <= '0;
		@(posedge clk_i);
	endtask : bus

	task automatic rd(input logic [7:0] idx, input logic [7:0] x);
		expq.push_back(x);
		bus(idx, 1'b0, 8'h00);
	endtask : rd

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d);
	endtask : wr

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	// Channels 0..3 supplies, 4..6 zones, 7 the 12V supply, 8..11 fans; edge values on purpose
	task automatic set_ch(input int k, input logic bad);
		if (k < 4 || k == 7)
			volt[(k == 7) ? 4 : k].reading <= bad ? (k[0] ? 8'hF1 : 8'h40) : (k[0] ? 8'h41 : 8'hF0);
		else if (k < 7)
			zone[k - 4].reading <= bad ? (k[0] ? 8'h20 : 8'h80) : (k[0] ? 8'h7F : 8'h21);
		else
			tach[k - 8].reading <= bad ? 16'h1001 : 16'h1000;
	endtask : set_ch

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] idx;
		logic [7:0] m;
		void'($urandom(32'h23B9B04D));
		for (int i = 0; i < N_VOLT; i++)
			volt[i] <= '{8'h41 + 8'($urandom % 175), 8'h40, 8'hF0};
		for (int i = 0; i < N_ZONE; i++)
			zone[i] <= '{8'h21 + 8'($urandom % 94), 8'h20, 8'h7F};
		for (int i = 0; i < N_FAN; i++)
			tach[i] <= '{16'($urandom % 4096), 16'h1000};
		tick(6);
		rst_i <= 1'b0;
		rd(PRI_IDX, RST_STATUS);
		rd(SEC_IDX, RST_STATUS);
		rd(CTRL_IDX, RST_CTRL);
		rd(IRQ_MASK_IDX, RST_MASK);
		rd(IRQ_STAT_IDX, RST_IRQ);
		$display("Done: reset values");
		set_ch(0, 1'b1);
		set_ch(8, 1'b1);
		wr(CTRL_IDX, 8'h06);
		wr(PRI_IDX, 8'hFF);
		wr(SEC_IDX, 8'hFF);
		tick(3);
		rd(PRI_IDX, 8'h00);
		rd(SEC_IDX, 8'h00);
		set_ch(0, 1'b0);
		set_ch(8, 1'b0);
		wr(CTRL_IDX, 8'h07);
		$display("Done: stopped monitoring");
		for (int k = 0; k < 12; k++) begin
			idx = (k < 7) ? PRI_IDX : SEC_IDX;
			m = 8'h01 << ((k < 7) ? k : (k == 7) ? 0 : k - 6);
			set_ch(k, 1'b1);
			tick(3);
			rd(idx, m);
			rd(idx, m);
			if (k > 6)
				rd(PRI_IDX, 8'h80);
			set_ch(k, 1'b0);
			tick(3);
			rd(idx, m);
			rd(idx, 8'h00);
		end
		tick(2);
		rd(PRI_IDX, 8'h00);
		$display("Done: latch and clear per channel");
		for (int d = 0; d < 2; d++) begin
			dfl <= 2'b01 << d;
			tick(3);
			rd(SEC_IDX, 8'h40 << d);
			wr(SEC_IDX, 8'h00);
			wr(PRI_IDX, 8'hFF);
			rd(SEC_IDX, 8'h40 << d);
			rd(PRI_IDX, 8'h80 | (8'h10 << 2 * d));
			wr(CTRL_IDX, 8'h07 & ~(8'h02 << d));
			tick(2);
			rd(SEC_IDX, 8'h00);
			rd(PRI_IDX, 8'h00);
			dfl <= 2'b00;
			wr(CTRL_IDX, 8'h07);
		end
		$display("Done: diode faults");
		sts3 <= 3'(1 + $urandom % 7);
		tick(3);
		rd(PRI_IDX, 8'h80);
		sts3 <= 3'b000;
		tick(3);
		rd(PRI_IDX, 8'h00);
		$display("Done: summary bit");
		`CHK(irq, 1'b0)
		rd(IRQ_STAT_IDX, 8'h03);
		rd(IRQ_STAT_IDX, 8'h00);
		rd(CTRL_IDX, 8'h07);
		wr(8'h7F, 8'hFF);
		rd(8'h7F, 8'h00);
		wr(IRQ_MASK_IDX, 8'h02);
		rd(IRQ_MASK_IDX, 8'h02);
		set_ch(0, 1'b1);
		tick(4);
		`CHK(irq, 1'b0)
		set_ch(7, 1'b1);
		tick(4);
		`CHK(irq, 1'b1)
		rd(IRQ_STAT_IDX, 8'h03);
		tick(2);
		`CHK(irq, 1'b0)
		$display("Done: interrupt");
		report_and_stop();
	end
endmodule : mis_status_tb
